// ### hdl/ppmm_pkg.sv
// Constants and types shared by the protected memory map block
package ppmm_pkg;
   // Address map
   localparam logic [14:0] PPMM_USER_LAST = 15'h7fbf;
   localparam logic [14:0] PPMM_KEY_RO_BASE = 15'h7fc0;
   localparam logic [14:0] PPMM_KEY_RO_LAST = 15'h7fc7;
   localparam logic [14:0] PPMM_KEY_FULL_BASE = 15'h7fc8;
   localparam logic [14:0] PPMM_KEY_FULL_LAST = 15'h7fcf;
   localparam logic [14:0] PPMM_ARM_ADDR = 15'h7fd0;
   localparam int PPMM_MEM_BYTES = 32768;
   localparam int PPMM_SP_BYTES = 64;
   // Protection arming
   localparam logic [7:0] PPMM_ARM_PATTERN = 8'haa;
   localparam logic [7:0] PPMM_ARM_RESET = 8'h00;
   // Scratchpad and address handling
   localparam logic [5:0] PPMM_SP_LAST_IDX = 6'h3f;
   localparam logic [2:0] PPMM_KEY_TAIL = 3'h7;
   localparam logic [15:0] PPMM_ADDR_KEEP_MASK = 16'h7fff;
   localparam logic [15:0] PPMM_KEY_ALIGN_MASK = 16'hfff8;
   // Fixed identity; all values arbitrary
   localparam logic [2:0] PPMM_REVISION = 3'h5; // Arbitrary revision value
   localparam logic [7:0] PPMM_FAMILY_CODE = 8'h5a;
   localparam logic [47:0] PPMM_SERIAL = 48'h0123_4567_89ab;
   localparam logic [7:0] PPMM_CHECK_CODE = 8'h3c;
   // Reset values
   localparam logic [63:0] PPMM_KEY_RESET = 64'h0;
   localparam logic [15:0] PPMM_TA_RESET = 16'h0;

   typedef enum logic [2:0] {
      PPMM_REG_USER = 3'b000,
      PPMM_REG_KEY_RO = 3'b001,
      PPMM_REG_KEY_FULL = 3'b010,
      PPMM_REG_ARM = 3'b011,
      PPMM_REG_RSVD = 3'b100
   } ppmm_region_t;

   typedef enum logic [1:0] {
      PPMM_ST_IDLE = 2'b00,
      PPMM_ST_COPY = 2'b01
   } ppmm_state_t;
endpackage

// ### hdl/ppmm_addr_decode.sv
// Address to memory region decoder
module ppmm_addr_decode
   import ppmm_pkg::*;
(
   // Address in
   input wire logic [15:0] addr_i,
   // Region out
   output ppmm_region_t region_o
);
   logic [14:0] a;
   assign a = addr_i[14:0];

   // Region by address range
   always_comb begin
      if (a <= PPMM_USER_LAST) begin
         region_o = PPMM_REG_USER;
      end else if (a <= PPMM_KEY_RO_LAST) begin
         region_o = PPMM_REG_KEY_RO;
      end else if (a <= PPMM_KEY_FULL_LAST) begin
         region_o = PPMM_REG_KEY_FULL;
      end else if (a == PPMM_ARM_ADDR) begin
         region_o = PPMM_REG_ARM;
      end else begin
         region_o = PPMM_REG_RSVD;
      end
   end
endmodule

// ### hdl/ppmm_key_check.sv
// Password comparison for read and full access
module ppmm_key_check
   import ppmm_pkg::*;
(
   // Keys
   input wire logic [63:0] key_i,
   input wire logic [63:0] key_ro_i,
   input wire logic [63:0] key_full_i,
   // Arming byte
   input wire logic [7:0] arm_i,
   // Grants
   output logic read_ok_o,
   output logic full_ok_o
);
   logic armed;
   assign armed = (arm_i == PPMM_ARM_PATTERN);
   // Full key opens read and copy, read key opens read only
   assign full_ok_o = !armed || (key_i == key_full_i);
   assign read_ok_o = full_ok_o || (key_i == key_ro_i);
endmodule

// ### hdl/ppmm_core.sv
// Password protected memory map with scratchpad, copy and read
module ppmm_core
   import ppmm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Scratchpad write session
   input wire logic ws_start_i,
   input wire logic [15:0] ws_ta_i,
   input wire logic ws_byte_valid_i,
   input wire logic [7:0] ws_byte_i,
   input wire logic ws_partial_i,
   // Scratchpad read and address registers
   input wire logic [5:0] sp_rd_idx_i,
   output logic [7:0] sp_rd_data_o,
   output logic [7:0] target_addr_low_o,
   output logic [7:0] target_addr_high_o,
   output logic [7:0] end_status_o,
   // Key sent with copy and read memory
   input wire logic [63:0] key_i,
   // Copy scratchpad
   input wire logic cp_req_i,
   input wire logic [7:0] cp_ta_low_i,
   input wire logic [7:0] cp_ta_high_i,
   input wire logic [7:0] cp_es_i,
   output logic cp_busy_o,
   output logic cp_done_o,
   output logic cp_ok_o,
   // Read memory
   input wire logic rm_open_i,
   input wire logic rm_close_i,
   input wire logic rm_byte_req_i,
   input wire logic [15:0] rm_addr_i,
   output logic rm_granted_o,
   output logic rm_denied_o,
   output logic rm_valid_o,
   output logic [7:0] rm_data_o,
   // Fixed identity
   output logic [7:0] chip_revision_o,
   output logic [63:0] rom_id_o
);
   typedef struct packed {
      ppmm_state_t st;
      logic [5:0] idx;
      logic sp_full;
      logic [15:0] ta;
      logic [5:0] ends;
      logic pf;
      logic aa;
      logic [7:0] arm;
      logic [63:0] key_ro;
      logic [63:0] key_full;
      logic rd_grant;
      logic rd_denied;
      logic rd_valid;
      logic [7:0] rd_data;
      logic [7:0] sp_data;
      logic cp_done;
      logic cp_ok;
   } ppmm_regs_t;

   ppmm_regs_t q, d;
   logic [7:0] mem [PPMM_MEM_BYTES];
   logic [7:0] sp [PPMM_SP_BYTES];
   logic [15:0] ws_ta_clip, cp_addr;
   ppmm_region_t ws_region, cp_region, ta_region, rm_region;
   logic read_ok, full_ok, sp_we, mem_we, cp_match, cp_accept;

   // Incoming target loses its top bit; key targets are 8-byte aligned
   assign ws_ta_clip = ws_ta_i & PPMM_ADDR_KEEP_MASK;
   assign cp_addr = {q.ta[15:6], q.idx};

   ppmm_addr_decode u_dec_ws (.addr_i(ws_ta_clip), .region_o(ws_region));
   ppmm_addr_decode u_dec_cp (.addr_i(cp_addr), .region_o(cp_region));
   ppmm_addr_decode u_dec_ta (.addr_i(q.ta), .region_o(ta_region));
   ppmm_addr_decode u_dec_rm (.addr_i(rm_addr_i), .region_o(rm_region));

   ppmm_key_check u_keys (
      .key_i(key_i),
      .key_ro_i(q.key_ro),
      .key_full_i(q.key_full),
      .arm_i(q.arm),
      .read_ok_o(read_ok),
      .full_ok_o(full_ok)
   );

   // Copy request checks: address bytes, E/S, key, whole keys
   assign cp_match = ({cp_ta_high_i, cp_ta_low_i} == q.ta) && (cp_es_i == {q.aa, q.pf, q.ends}) && !q.pf;
   assign cp_accept = cp_req_i && (q.st == PPMM_ST_IDLE) && cp_match && full_ok
      && !(((ta_region == PPMM_REG_KEY_RO) || (ta_region == PPMM_REG_KEY_FULL))
      && (q.ends[2:0] != PPMM_KEY_TAIL));

   // Next state
   always_comb begin
      d = q;
      d.cp_done = 1'b0;
      d.cp_ok = 1'b0;
      d.rd_denied = 1'b0;
      d.rd_valid = 1'b0;
      sp_we = 1'b0;
      mem_we = 1'b0;
      d.sp_data = sp[sp_rd_idx_i];
      case (q.st)
         PPMM_ST_IDLE: begin
            if (ws_start_i) begin
               if ((ws_region == PPMM_REG_KEY_RO) || (ws_region == PPMM_REG_KEY_FULL)) begin
                  d.ta = ws_ta_clip & PPMM_KEY_ALIGN_MASK;
               end else begin
                  d.ta = ws_ta_clip;
               end
               d.idx = d.ta[5:0];
               d.ends = d.ta[5:0];
               d.pf = 1'b1;
               d.aa = 1'b0;
               d.sp_full = 1'b0;
            end else if (ws_byte_valid_i && !q.sp_full) begin
               sp_we = 1'b1;
               d.ends = q.idx;
               d.pf = 1'b0;
               d.idx = q.idx + 6'h01;
               d.sp_full = (q.idx == PPMM_SP_LAST_IDX);
            end
            // Partial byte sets the flag even beside a clearing byte
            if (ws_partial_i) begin
               d.pf = 1'b1;
            end
            if (cp_req_i) begin
               d.cp_done = !cp_accept;
               if (cp_accept) begin
                  d.st = PPMM_ST_COPY;
                  d.idx = q.ta[5:0];
               end
            end
         end
         PPMM_ST_COPY: begin
            case (cp_region)
               PPMM_REG_USER: mem_we = 1'b1;
               PPMM_REG_KEY_RO: d.key_ro[q.idx[2:0] * 8 +: 8] = sp[q.idx];
               PPMM_REG_KEY_FULL: d.key_full[q.idx[2:0] * 8 +: 8] = sp[q.idx];
               PPMM_REG_ARM: d.arm = sp[q.idx];
               default: d.arm = q.arm; // Reserved bytes dropped
            endcase
            if (q.idx == q.ends) begin
               d.st = PPMM_ST_IDLE;
               d.aa = 1'b1;
               d.cp_done = 1'b1;
               d.cp_ok = 1'b1;
               d.idx = q.ta[5:0];
            end else begin
               d.idx = q.idx + 6'h01;
            end
         end
         default: d.st = PPMM_ST_IDLE;
      endcase
      // Read memory session
      if (rm_open_i) begin
         d.rd_grant = read_ok;
         d.rd_denied = !read_ok;
      end else if (rm_close_i) begin
         d.rd_grant = 1'b0;
      end
      if (rm_byte_req_i && q.rd_grant) begin
         d.rd_valid = 1'b1;
         if (rm_region == PPMM_REG_USER) begin
            d.rd_data = mem[rm_addr_i[14:0]];
         end else if (rm_region == PPMM_REG_ARM) begin
            d.rd_data = q.arm;
         end else begin
            d.rd_data = 8'h00;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.st <= PPMM_ST_IDLE;
         q.ta <= PPMM_TA_RESET;
         q.arm <= PPMM_ARM_RESET;
         q.key_ro <= PPMM_KEY_RESET;
         q.key_full <= PPMM_KEY_RESET;
      end else begin
         q <= d;
      end
   end

   // Scratchpad and memory arrays, no reset
   always_ff @(posedge clk_i) begin
      if (sp_we) begin
         sp[q.idx] <= ws_byte_i;
      end
      if (mem_we) begin
         mem[cp_addr[14:0]] <= sp[q.idx];
      end
   end

   // Outputs
   assign sp_rd_data_o = q.sp_data;
   assign target_addr_low_o = q.ta[7:0];
   assign target_addr_high_o = q.ta[15:8];
   assign end_status_o = {q.aa, q.pf, q.ends};
   assign cp_busy_o = (q.st == PPMM_ST_COPY);
   assign cp_done_o = q.cp_done;
   assign cp_ok_o = q.cp_ok;
   assign rm_granted_o = q.rd_grant;
   assign rm_denied_o = q.rd_denied;
   assign rm_valid_o = q.rd_valid;
   assign rm_data_o = q.rd_data;
   assign chip_revision_o = {PPMM_REVISION, 5'h00};
   assign rom_id_o = {PPMM_CHECK_CODE, PPMM_SERIAL, PPMM_FAMILY_CODE};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_copy_go;
      cp_req_i && (q.st == PPMM_ST_IDLE) && cp_match && (q.arm == PPMM_ARM_PATTERN) && (key_i == q.key_full)
         && (ta_region != PPMM_REG_KEY_RO) && (ta_region != PPMM_REG_KEY_FULL);
   endsequence
   sequence s_copy_run;
      (q.st == PPMM_ST_COPY) ##1 1'b1;
   endsequence

   property p_full_key_copies;
      s_copy_go |=> s_copy_run;
   endproperty
   a_full_key_copies: assert property (p_full_key_copies) else $error("full key copy not started");

   property p_ro_key_no_copy;
      cp_req_i && (q.st == PPMM_ST_IDLE) && (q.arm == PPMM_ARM_PATTERN) && (key_i != q.key_full)
         |=> cp_done_o && !cp_ok_o && !cp_busy_o;
   endproperty
   a_ro_key_no_copy: assert property (p_ro_key_no_copy) else $error("copy ran without full key");

   property p_bad_key_denied;
      rm_open_i && (q.arm == PPMM_ARM_PATTERN) && (key_i != q.key_ro) && (key_i != q.key_full)
         |=> !rm_granted_o && rm_denied_o;
   endproperty
   a_bad_key_denied: assert property (p_bad_key_denied) else $error("read granted on wrong key");

   property p_disarmed_any_key;
      rm_open_i && (q.arm != PPMM_ARM_PATTERN) |=> rm_granted_o && !rm_denied_o;
   endproperty
   a_disarmed_any_key: assert property (p_disarmed_any_key) else $error("disarmed read refused");

   property p_key_not_readable;
      rm_byte_req_i && rm_granted_o && (rm_region != PPMM_REG_USER) && (rm_region != PPMM_REG_ARM)
         |=> rm_valid_o && (rm_data_o == 8'h00);
   endproperty
   a_key_not_readable: assert property (p_key_not_readable) else $error("key or reserved byte returned");

   property p_key_align;
      ws_start_i && (q.st == PPMM_ST_IDLE) && (ws_region inside {PPMM_REG_KEY_RO, PPMM_REG_KEY_FULL})
         |=> (q.ta[2:0] == 3'h0) && q.pf && !q.aa;
   endproperty
   a_key_align: assert property (p_key_align) else $error("key target not aligned");

   property p_ta_mismatch;
      cp_req_i && (q.st == PPMM_ST_IDLE) && ({cp_ta_high_i, cp_ta_low_i} != q.ta) |=> cp_done_o && !cp_ok_o;
   endproperty
   a_ta_mismatch: assert property (p_ta_mismatch) else $error("copy ran on wrong target");

   property p_copy_end;
      cp_busy_o && (q.idx == q.ends) |=> !cp_busy_o && cp_ok_o && end_status_o[7];
   endproperty
   a_copy_end: assert property (p_copy_end) else $error("copy did not finish");

   property p_sp_write_free;
      ws_byte_valid_i && !ws_start_i && !ws_partial_i && (q.st == PPMM_ST_IDLE) && !q.sp_full
         |=> !end_status_o[6];
   endproperty
   a_sp_write_free: assert property (p_sp_write_free) else $error("scratchpad write blocked");

   property p_partial_sets_pf;
      ws_partial_i && (q.st == PPMM_ST_IDLE) |=> end_status_o[6];
   endproperty
   a_partial_sets_pf: assert property (p_partial_sets_pf) else $error("partial flag not set");

   property p_good_key_reads;
      rm_open_i && (q.arm == PPMM_ARM_PATTERN) && ((key_i == q.key_ro) || (key_i == q.key_full))
         |=> rm_granted_o && !rm_denied_o;
   endproperty
   a_good_key_reads: assert property (p_good_key_reads) else $error("read refused on matching key");

   property p_revision_low_zero;
      chip_revision_o[4:0] == 5'h00;
   endproperty
   a_revision_low_zero: assert property (p_revision_low_zero) else $error("revision low bits set");
endmodule

// ### test/ppmm_master_model.sv
// Bus master model issuing write, copy and read requests to the core
module ppmm_master_model
   import ppmm_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Requests towards the core
   output logic ws_start_i,
   output logic [15:0] ws_ta_i,
   output logic ws_byte_valid_i,
   output logic [7:0] ws_byte_i,
   output logic ws_partial_i,
   output logic [5:0] sp_rd_idx_i,
   output logic [63:0] key_i,
   output logic cp_req_i,
   output logic [7:0] cp_ta_low_i,
   output logic [7:0] cp_ta_high_i,
   output logic [7:0] cp_es_i,
   output logic rm_open_i,
   output logic rm_close_i,
   output logic rm_byte_req_i,
   output logic [15:0] rm_addr_i,
   // Answers from the core
   input wire logic [7:0] sp_rd_data_o,
   input wire logic cp_done_o,
   input wire logic cp_ok_o,
   input wire logic rm_granted_o,
   input wire logic rm_denied_o,
   input wire logic rm_valid_o,
   input wire logic [7:0] rm_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels at time zero
   initial begin
      {ws_start_i, ws_byte_valid_i, ws_partial_i, cp_req_i, rm_open_i, rm_close_i, rm_byte_req_i} = '0;
      {ws_ta_i, ws_byte_i, sp_rd_idx_i, key_i, cp_ta_low_i, cp_ta_high_i, cp_es_i, rm_addr_i} = '0;
   end

   // Scratchpad write of sixteen whole bytes, lowest byte first
   task automatic wr(input logic [15:0] ta, input logic [127:0] dat);
      @(negedge clk_i);
      ws_start_i = 1'b1;
      ws_ta_i = ta;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk_i);
         ws_start_i = 1'b0;
         ws_byte_valid_i = 1'b1;
         ws_byte_i = dat[8*i+:8];
      end
      @(negedge clk_i);
      ws_byte_valid_i = 1'b0;
      ws_byte_i = ~ws_byte_i;
      ws_ta_i = ~ws_ta_i;
   endtask

   // Copy request, waits a bounded time for completion
   task automatic cp(input logic [15:0] ta, input logic [7:0] es, input logic [63:0] key, output logic ok);
      @(negedge clk_i);
      cp_req_i = 1'b1;
      cp_ta_low_i = ta[7:0];
      cp_ta_high_i = ta[15:8];
      cp_es_i = es;
      key_i = key;
      @(negedge clk_i);
      cp_req_i = 1'b0;
      ok = 1'bx;
      for (int i = 0; i < 100; i++) begin
         if (cp_done_o === 1'b1) begin
            ok = cp_ok_o;
            break;
         end
         @(negedge clk_i);
      end
   endtask

   // Close any session, then open a read session with a key
   task automatic op(input logic [63:0] key, output logic g, output logic dn);
      @(negedge clk_i);
      rm_close_i = 1'b1;
      @(negedge clk_i);
      rm_close_i = 1'b0;
      rm_open_i = 1'b1;
      key_i = key;
      @(negedge clk_i);
      rm_open_i = 1'b0;
      g = rm_granted_o;
      dn = rm_denied_o;
   endtask

   // One memory byte read
   task automatic rd(input logic [15:0] a, output logic v, output logic [7:0] d);
      @(negedge clk_i);
      rm_byte_req_i = 1'b1;
      rm_addr_i = a;
      @(negedge clk_i);
      rm_byte_req_i = 1'b0;
      rm_addr_i = ~a;
      v = rm_valid_o;
      d = rm_data_o;
   endtask

   // Incomplete last byte of a write session
   task automatic part();
      @(negedge clk_i);
      ws_partial_i = 1'b1;
      @(negedge clk_i);
      ws_partial_i = 1'b0;
   endtask

   // One scratchpad byte read
   task automatic sp(input logic [5:0] i, output logic [7:0] d);
      @(negedge clk_i);
      sp_rd_idx_i = i;
      @(negedge clk_i);
      d = sp_rd_data_o;
   endtask
endmodule

// ### test/tb_ppmm_core.sv
// Self-checking testbench for the protected memory map core
module tb_ppmm_core;
   timeunit 1ns;
   timeprecision 1ps;
   import ppmm_pkg::*;
   localparam logic [63:0] KRO = 64'h8877_6655_4433_2211;
   localparam logic [63:0] KFU = 64'h0f1e_2d3c_4b5a_6978;
   localparam logic [127:0] UDAT = 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ws_start_i, ws_byte_valid_i, ws_partial_i, cp_req_i, rm_open_i, rm_close_i, rm_byte_req_i;
   logic [15:0] ws_ta_i, rm_addr_i;
   logic [7:0] ws_byte_i, cp_ta_low_i, cp_ta_high_i, cp_es_i, sp_rd_data_o, rm_data_o, chip_revision_o;
   logic [7:0] target_addr_low_o, target_addr_high_o, end_status_o;
   logic [5:0] sp_rd_idx_i;
   logic [63:0] key_i, rom_id_o;
   logic cp_busy_o, cp_done_o, cp_ok_o, rm_granted_o, rm_denied_o, rm_valid_o;
   logic ok, g, dn, v;
   logic [7:0] d;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_busy = 0;

   ppmm_core uut (.*);
   ppmm_master_model mdl (.*);

   // Clock at 125 MHz
   always #4 clk_i = ~clk_i;

   // Value comparison
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Copy busy cycle count
   always @(negedge clk_i) begin
      if (cp_busy_o === 1'b1) n_busy++;
   end

   // Hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         close_out();
      end
   end

   // Test sequence
   initial begin
      repeat (10) @(negedge clk_i);
      rst_b_i = 1'b1;
      chk(64'(chip_revision_o), 64'({PPMM_REVISION, 5'h00}));
      chk(rom_id_o, {PPMM_CHECK_CODE, PPMM_SERIAL, PPMM_FAMILY_CODE});
      mdl.op(64'h0, g, dn);
      chk(64'({g, dn}), 64'h2);
      mdl.rd(16'(PPMM_ARM_ADDR), v, d);
      chk(64'({v, d}), 64'({1'b1, PPMM_ARM_RESET}));
      $display("test reset defaults done");
      mdl.wr(16'h1030, UDAT);
      chk(64'({target_addr_high_o, target_addr_low_o, end_status_o}), 64'h10303f);
      mdl.sp(6'h31, d);
      chk(64'(d), 64'(UDAT[15:8]));
      mdl.cp(16'h1030, 8'h3e, 64'h0, ok);
      chk(64'(ok), 64'h0);
      mdl.cp(16'h1031, 8'h3f, 64'h0, ok);
      chk(64'(ok), 64'h0);
      chk(64'(n_busy), 64'h0);
      mdl.cp(16'h1030, 8'h3f, 64'h5, ok);
      chk(64'(ok), 64'h1);
      chk(64'(end_status_o), 64'hbf);
      chk(64'(n_busy), 64'h10);
      for (int i = 0; i < 16; i++) begin
         mdl.rd(16'h1030 + 16'(i), v, d);
         chk(64'({v, d}), 64'({1'b1, UDAT[8*i+:8]}));
      end
      $display("test user page done");
      mdl.wr(16'h2000, UDAT);
      mdl.part();
      chk(64'({target_addr_high_o, target_addr_low_o, end_status_o}), 64'h20004f);
      mdl.cp(16'h2000, 8'h4f, 64'h0, ok);
      chk(64'(ok), 64'h0);
      $display("test partial byte done");
      mdl.wr(16'h7fc3, {KFU, KRO});
      chk(64'({target_addr_high_o, target_addr_low_o, end_status_o}), 64'h7fc00f);
      mdl.cp(16'h7fc0, 8'h0f, 64'h0, ok);
      chk(64'(ok), 64'h1);
      chk(64'(n_busy), 64'h20);
      mdl.sp(6'h00, d);
      chk(64'(d), 64'(KRO[7:0]));
      mdl.rd(16'h7fc0, v, d);
      chk(64'({v, d}), 64'h100);
      mdl.rd(16'h7fcf, v, d);
      chk(64'({v, d}), 64'h100);
      mdl.rd(16'h7fd5, v, d);
      chk(64'({v, d}), 64'h100);
      $display("test key setup done");
      mdl.wr(16'h7fd0, 128'hab);
      mdl.cp(16'h7fd0, 8'h1f, 64'h0, ok);
      chk(64'(ok), 64'h1);
      mdl.op(64'h3, g, dn);
      chk(64'({g, dn}), 64'h2);
      mdl.wr(16'h7fd0, 128'haa);
      mdl.cp(16'h7fd0, 8'h1f, 64'h0, ok);
      chk(64'(ok), 64'h1);
      mdl.rd(16'(PPMM_ARM_ADDR), v, d);
      chk(64'({v, d}), 64'h1aa);
      $display("test arming done");
      mdl.op(KFU ^ 64'h1, g, dn);
      chk(64'({g, dn}), 64'h1);
      mdl.rd(16'h1030, v, d);
      chk(64'(v), 64'h0);
      mdl.op(KRO, g, dn);
      chk(64'({g, dn}), 64'h2);
      mdl.rd(16'h1030, v, d);
      chk(64'({v, d}), 64'({1'b1, UDAT[7:0]}));
      mdl.cp(16'h7fd0, 8'h9f, KRO, ok);
      chk(64'(ok), 64'h0);
      mdl.cp(16'h7fd0, 8'h9f, KFU ^ 64'h80, ok);
      chk(64'(ok), 64'h0);
      mdl.cp(16'h7fd0, 8'h9f, KFU, ok);
      chk(64'(ok), 64'h1);
      mdl.op(KFU, g, dn);
      chk(64'({g, dn}), 64'h2);
      mdl.sp(6'h10, d);
      chk(64'(d), 64'haa);
      $display("test armed access done");
      rst_b_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rst_b_i = 1'b1;
      mdl.op(64'h7, g, dn);
      chk(64'({g, dn}), 64'h2);
      mdl.rd(16'(PPMM_ARM_ADDR), v, d);
      chk(64'({v, d}), 64'({1'b1, PPMM_ARM_RESET}));
      $display("test mid-run reset done");
      close_out();
   end
endmodule
